// ---- hw/reset_ctl_defines.vh ----
/*
 * constants for the chip reset and supply-drop control block.
 * assumes a 100 MHz system clock and comparator outputs from the analog
 * supply monitors that are already hysteretic or need light filtering.
 */
// Functional notes
// R1: Pin, watchdog, power-on or supply-drop cause resets the chip.
// R2: Any reset starts the wake timer; release needs pin, osc, count, flash.
// R3: On release the processor fetches from address zero, the reset vector.
// R4: All registers hold reset values when the internal reset is released.
// R5: Supply under the upper threshold warns the interrupt controller.
// R6: The warning interrupts only when enabled; its level stays readable.
// R7: Supply below the lower threshold asserts chip reset to protect flash.
// R8: Supply-drop reset holds down to the floor, then power-on reset holds.
// R9: Both thresholds have hysteresis so indications do not chatter.
// R10: Execution starts only once the oscillator is judged stable.
// R11: Causes are synchronised for release and status; assertion is at once.
`ifndef RESET_CTL_DEFINES_VH
`define RESET_CTL_DEFINES_VH

`define CLK_PERIOD_NS     10
`define WAKE_TIME_NS      40960
`define WAKE_CYCLES       (`WAKE_TIME_NS / `CLK_PERIOD_NS)
`define WAKE_CNT_W        13
`define WAKE_LAST_CNT     13'hfff
`define OSC_STABLE_CYCLES 8'h40
`define FILT_CYCLES       4'h8
`define FILT_CNT_W        4
`define RESET_VECTOR      32'h0000_0000

`endif

// ---- hw/level_filter.v ----
/*
 * synchroniser plus hysteresis filter for one asynchronous level.
 * assumes the input may change at any time relative to clk_sys.
 */
`timescale 1ns/100ps
`include "reset_ctl_defines.vh"

module level_filter
(
   clk_sys,
   rst_b,
   level_in,
   level_out
);
   input  wire clk_sys;
   input  wire rst_b;
   input  wire level_in;
   output reg  level_out;

   reg                   meta_q;
   reg                   sync_q;
   reg [`FILT_CNT_W-1:0] cnt_q;

   // output flips only after the input stays changed for a full window
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q    <= 1'b0;
         sync_q    <= 1'b0;
         cnt_q     <= {`FILT_CNT_W{1'b0}};
         level_out <= 1'b0;
      end
      else
      begin
         meta_q <= level_in;
         sync_q <= meta_q; // R11
         if (sync_q == level_out)
            cnt_q <= {`FILT_CNT_W{1'b0}};
         else if (cnt_q == `FILT_CYCLES - 4'h1)
         begin
            cnt_q     <= {`FILT_CNT_W{1'b0}};
            level_out <= sync_q; // R9
         end
         else
            cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// ---- hw/reset_and_brownout_control.v ----
/*
 * chip reset merge, wake-up timer and two-stage supply-drop monitor.
 * assumes rst_b is the power-on reset, that the supply comparators
 * already carry analog hysteresis, and that the processor fetches from
 * fetch_addr once cpu_rst_b rises.
 */
`timescale 1ns/100ps
`include "reset_ctl_defines.vh"

module reset_and_brownout_control
(
   clk_sys,
   rst_b,
   ext_rst_b,
   wdt_rst,
   supply_below_upper,
   supply_below_lower,
   osc_running,
   flash_init_done,
   lv_irq_en,
   chip_rst_b,
   cpu_rst_b,
   fetch_addr,
   lv_warn_irq,
   lv_warn_status,
   rst_cause
);
   input  wire        clk_sys;
   input  wire        rst_b;
   input  wire        ext_rst_b;
   input  wire        wdt_rst;
   input  wire        supply_below_upper;
   input  wire        supply_below_lower;
   input  wire        osc_running;
   input  wire        flash_init_done;
   input  wire        lv_irq_en;
   output reg         chip_rst_b;
   output reg         cpu_rst_b;
   output reg  [31:0] fetch_addr;
   output reg         lv_warn_irq;
   output reg         lv_warn_status;
   output reg  [3:0]  rst_cause;

   localparam [1:0] ST_HOLD = 2'h0;
   localparam [1:0] ST_WAKE = 2'h1;
   localparam [1:0] ST_RUN  = 2'h2;

   // last wake count, one below the wake cycle total
   localparam [`WAKE_CNT_W-1:0] WAKE_LAST = `WAKE_LAST_CNT;

   ////////////////////////////////////////////////////////////////////////
   // asynchronous reset merge: assertion acts at once, release is synced

   wire ext_pin_n;
   wire wdt_n;
   wire drop_n;
   wire any_rst_b;
   reg  rmeta_q;
   reg  rsync_q;

   assign ext_pin_n = ext_rst_b;
   assign wdt_n     = ~wdt_rst;
   // below lower threshold stays asserted toward the floor; power-on
   // reset takes over there through rst_b
   assign drop_n    = ~supply_below_lower; // R7 R8
   assign any_rst_b = rst_b & ext_pin_n & wdt_n & drop_n; // R1

   always @(posedge clk_sys or negedge any_rst_b)
   begin
      if (!any_rst_b)
      begin
         rmeta_q <= 1'b0;
         rsync_q <= 1'b0;
      end
      else
      begin
         rmeta_q <= 1'b1;
         rsync_q <= rmeta_q; // R11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // filtered levels for release conditions and warning

   wire ext_rel;
   wire osc_ok;
   wire warn_lvl;
   wire lower_lvl;

   level_filter u_ext_f
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .level_in  (ext_rst_b),
      .level_out (ext_rel)
   );

   level_filter u_osc_f
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .level_in  (osc_running),
      .level_out (osc_ok)
   );

   level_filter u_upper_f
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .level_in  (supply_below_upper),
      .level_out (warn_lvl) // R9
   );

   level_filter u_lower_f
   (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .level_in  (supply_below_lower),
      .level_out (lower_lvl)
   );

   ////////////////////////////////////////////////////////////////////////
   // wake-up sequencer

   reg [1:0]             state_q;
   reg [`WAKE_CNT_W-1:0] wake_q;
   reg [7:0]             osc_q;
   wire                  osc_stable;

   assign osc_stable = (osc_q == `OSC_STABLE_CYCLES); // R10

   // this domain is reset by every cause, so any reset restarts the timer
   always @(posedge clk_sys or negedge rsync_q)
   begin
      if (!rsync_q)
      begin
         state_q    <= ST_HOLD;
         wake_q     <= {`WAKE_CNT_W{1'b0}};
         osc_q      <= 8'h00;
         chip_rst_b <= 1'b0;
         cpu_rst_b  <= 1'b0;
         fetch_addr <= `RESET_VECTOR; // R3
      end
      else
      begin
         // oscillator must run without a drop for a settle window
         if (!osc_ok)
            osc_q <= 8'h00;
         else if (!osc_stable)
            osc_q <= osc_q + 8'h01; // R10
         case (state_q)
            ST_HOLD:
            begin
               wake_q <= {`WAKE_CNT_W{1'b0}};
               if (ext_rel && !lower_lvl)
                  state_q <= ST_WAKE; // R2
            end
            ST_WAKE:
            begin
               if (!ext_rel || lower_lvl)
                  state_q <= ST_HOLD;
               else if (wake_q != WAKE_LAST)
                  wake_q <= wake_q + 13'h0001; // R2
               else if (osc_stable && flash_init_done)
               begin
                  // peripherals leave reset one cycle before the cpu, so
                  // all registers are settled when fetching starts
                  chip_rst_b <= 1'b1; // R4
                  state_q    <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               cpu_rst_b  <= 1'b1; // R2
               fetch_addr <= `RESET_VECTOR; // R3
            end
            default:
               state_q <= ST_HOLD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // cause synchronisers for status only; raw pins, not filtered levels,
   // so a short pulse that reset the chip is still recorded

   reg  [2:0] cmeta_q;
   reg  [2:0] csync_q;
   wire [2:0] cause_raw;

   assign cause_raw = {supply_below_lower, wdt_rst, ~ext_rst_b};

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cmeta_q <= 3'h0;
         csync_q <= 3'h0;
      end
      else
      begin
         cmeta_q <= cause_raw;
         csync_q <= cmeta_q; // R11
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low-voltage warning and reset cause capture

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lv_warn_status <= 1'b0;
         lv_warn_irq    <= 1'b0;
         rst_cause      <= 4'h1;
      end
      else
      begin
         lv_warn_status <= warn_lvl; // R5 R6
         lv_warn_irq    <= warn_lvl & lv_irq_en; // R5 R6
         // sticky, cleared only by power-on; order is supply drop,
         // watchdog, pin, power-on
         rst_cause <= rst_cause | {csync_q, 1'b0}; // R1 R11
      end
   end
endmodule

// ---- verification/flash_model.sv ----
/* flash controller stand-in: init restarts whenever chip reset falls.
   assumes chip_rst_b from the block under test; slow picks long init. */
`timescale 1ns/100ps
module flash_model #(parameter int DLY = 13'h1100)
(
   input  wire  clk_sys,
   input  wire  rst_b,
   input  wire  chip_rst_b,
   input  wire  slow,
   output logic flash_init_done
);
   logic [12:0] cnt_q;
   logic        chip_q;
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         chip_q <= 1'b0;
         cnt_q  <= 13'h0;
      end
      else
      begin
         chip_q <= chip_rst_b;
         // a fresh chip reset restarts the init count
         if (chip_q && !chip_rst_b)
            cnt_q <= 13'h0;
         else if (cnt_q < DLY)
            cnt_q <= cnt_q + 13'h1;
      end
   end
   // slow init outlasts the wake timer so the flash gates release
   assign flash_init_done = cnt_q >= (slow ? DLY : 13'h4);
endmodule

// ---- verification/rbc_chk_sva.sv ----
/* checker for reset_and_brownout_control.
   assumes a bind to the top module and its single clock. */
`timescale 1ns/100ps
`include "reset_ctl_defines.vh"
module rbc_chk
(
   input wire        clk_sys,
   input wire        rst_b,
   input wire        ext_rst_b,
   input wire        wdt_rst,
   input wire        supply_below_upper,
   input wire        supply_below_lower,
   input wire        osc_running,
   input wire        flash_init_done,
   input wire        lv_irq_en,
   input wire        chip_rst_b,
   input wire        cpu_rst_b,
   input wire        lv_warn_irq,
   input wire        lv_warn_status,
   input wire [31:0] fetch_addr,
   input wire [3:0]  rst_cause
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   int low_n;
   always @(posedge clk_sys or negedge rst_b)
      if (!rst_b) low_n <= 0;
      else low_n <= chip_rst_b ? 0 : low_n + 1;
   sequence s_up; $rose(chip_rst_b) ##1 cpu_rst_b; endsequence
   property p_cause; (!ext_rst_b || wdt_rst || supply_below_lower)
      |-> !chip_rst_b && !cpu_rst_b; endproperty
   property p_cpu_next; $rose(chip_rst_b) |-> s_up; endproperty
   property p_fetch; cpu_rst_b |-> chip_rst_b && fetch_addr == 32'h0;
   endproperty
   property p_release; $rose(chip_rst_b) |-> osc_running && ext_rst_b
      && flash_init_done && low_n >= `WAKE_CYCLES; endproperty
   property p_irq_en; !lv_irq_en [*2] |-> !lv_warn_irq; endproperty
   property p_warn; $rose(lv_warn_status) |->
      $past(supply_below_upper, 4) && $past(supply_below_upper, 8);
   endproperty
   property p_sticky; $past(rst_b) |-> ($past(rst_cause) & ~rst_cause) == 4'h0;
   endproperty
   property p_wdt; wdt_rst [*2] |-> ##[0:4] rst_cause[2]; endproperty
   a_cause: assert property (p_cause) else $error("reset not asserted");
   a_cpu_next: assert property (p_cpu_next) else $error("cpu late");
   a_fetch: assert property (p_fetch) else $error("bad fetch");
   a_release: assert property (p_release) else $error("early");
   a_irq_en: assert property (p_irq_en) else $error("irq masked");
   a_warn: assert property (p_warn) else $error("warn glitch");
   a_sticky: assert property (p_sticky) else $error("cause lost");
   a_wdt: assert property (p_wdt) else $error("wdt cause");
endmodule
bind reset_and_brownout_control rbc_chk u_chk
(
   .clk_sys            (clk_sys),
   .rst_b              (rst_b),
   .ext_rst_b          (ext_rst_b),
   .wdt_rst            (wdt_rst),
   .supply_below_upper (supply_below_upper),
   .supply_below_lower (supply_below_lower),
   .osc_running        (osc_running),
   .flash_init_done    (flash_init_done),
   .lv_irq_en          (lv_irq_en),
   .chip_rst_b         (chip_rst_b),
   .cpu_rst_b          (cpu_rst_b),
   .lv_warn_irq        (lv_warn_irq),
   .lv_warn_status     (lv_warn_status),
   .fetch_addr         (fetch_addr),
   .rst_cause          (rst_cause)
);

// ---- verification/test_reset_and_brownout_control.sv ----
/* self-checking bench for reset_and_brownout_control.
   assumes the defines header, flash_model and the checker compiled. */
`timescale 1ns/100ps
`include "reset_ctl_defines.vh"
module test_reset_and_brownout_control;
   logic clk_sys = 0, rst_b = 0, ext_rst_b = 1, wdt_rst = 0, slow = 1;
   logic supply_below_upper = 0, supply_below_lower = 0, osc_running = 1;
   logic lv_irq_en = 0;
   wire flash_init_done, chip_rst_b, cpu_rst_b, lv_warn_irq, lv_warn_status;
   wire [31:0] fetch_addr;
   wire [3:0]  rst_cause;
   int errors = 0, n_checks = 0, i, n;
   logic [16:0] lf = 17'h13355;
   logic [3:0]  exp_c;
   always #5 clk_sys = ~clk_sys;
   reset_and_brownout_control dut
   (
      .clk_sys            (clk_sys),
      .rst_b              (rst_b),
      .ext_rst_b          (ext_rst_b),
      .wdt_rst            (wdt_rst),
      .supply_below_upper (supply_below_upper),
      .supply_below_lower (supply_below_lower),
      .osc_running        (osc_running),
      .flash_init_done    (flash_init_done),
      .lv_irq_en          (lv_irq_en),
      .chip_rst_b         (chip_rst_b),
      .cpu_rst_b          (cpu_rst_b),
      .fetch_addr         (fetch_addr),
      .lv_warn_irq        (lv_warn_irq),
      .lv_warn_status     (lv_warn_status),
      .rst_cause          (rst_cause)
   );
   flash_model fm
   (
      .clk_sys         (clk_sys),
      .rst_b           (rst_b),
      .chip_rst_b      (chip_rst_b),
      .slow            (slow),
      .flash_init_done (flash_init_done)
   );
   ////////////////////////////////////////////////////////////////////////
   function logic [16:0] nxt(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   function logic [3:0] cause_bit(input int k);
      return 4'h2 << k;
   endfunction
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // samples on the falling edge, where outputs have settled
   task wait_up;
      n = 0;
      while (cpu_rst_b !== 1'b1 && n < 9000)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(cpu_rst_b, 1);
   endtask
   task pulse(input int k, input int len);
      @(posedge clk_sys);
      case (k)
         0: ext_rst_b <= 0;
         1: wdt_rst <= 1;
         default: supply_below_lower <= 1;
      endcase
      repeat (len) @(posedge clk_sys);
      ext_rst_b <= 1;
      wdt_rst <= 0;
      supply_below_lower <= 0;
   endtask
   task conclude;
      $display("errors=%0d n_checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #600000;
      errors++;
      conclude;
   end
   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1;
      wait_up;
      chk(n >= `WAKE_CYCLES, 1);
      chk(fetch_addr, 32'h0);
      exp_c = 4'h1;
      for (i = 0; i < 3; i++)
      begin
         lf = nxt(lf);
         slow <= lf[0];
         pulse(i, 2 + lf[4:1]);
         // a second pin pulse mid-wake must restart the whole count
         if (i == 0)
         begin
            repeat (2000) @(posedge clk_sys);
            pulse(0, 12);
         end
         if (i == 1)
         begin
            osc_running <= 0;
            repeat (4300) @(posedge clk_sys);
            chk(cpu_rst_b, 0);
            osc_running <= 1;
         end
         wait_up;
         chk(n >= (i == 1 ? 64 : `WAKE_CYCLES), 1);
         exp_c = exp_c | cause_bit(i);
         chk(rst_cause, exp_c);
      end
      for (i = 0; i < 4; i++)
      begin
         lf = nxt(lf);
         @(posedge clk_sys);
         lv_irq_en <= lf[0];
         supply_below_upper <= 1;
         repeat (1 + lf[2:1]) @(posedge clk_sys);
         supply_below_upper <= 0;
         repeat (15) @(posedge clk_sys);
         chk(lv_warn_status, 0);
         supply_below_upper <= 1;
         repeat (20) @(posedge clk_sys);
         chk(lv_warn_status, 1);
         chk(lv_warn_irq, lf[0]);
         chk(chip_rst_b, 1);
         supply_below_upper <= 0;
         repeat (20) @(posedge clk_sys);
         chk(lv_warn_status, 0);
      end
      rst_b <= 0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1;
      wait_up;
      chk(rst_cause, 4'h1);
      chk(n >= `WAKE_CYCLES, 1);
      conclude;
   end
endmodule
